// File: core/mqp_regs.sv
/*
  message queue pointer registers behind an apb slave.
  assumes device logic on pclk gives one-cycle advance strobes.
*/
`timescale 1ns/100ps

module mqp_regs #(
  parameter int unsigned APB_AW = 12
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_AW-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // device side
  input  wire mqp_pkg::mqp_inc_type  dev_inc,
  output mqp_pkg::mqp_addr_type      queue_addr,
  output mqp_pkg::mqp_flags_type     queue_flags
);

  if (APB_AW < mqp_pkg::AW) begin : g_aw_check
    $error("APB_AW too small for the register window");
  end

  // ****************************************************
  // control register
  // ****************************************************
  logic [11:0] queue_base_addr_r;
  logic [2:0]  size_r;
  logic        bottom_read_option_r;
  logic        queue_access_disable_r;
  logic [11:0] addr;
  logic        setup;
  logic        wr_acc;
  logic        hit_ctrl;
  logic        hit_stat;
  logic [6:0]  hit_ptr;
  logic        hit_any;

  assign addr     = paddr[11:0];
  assign setup    = psel && !penable;
  assign wr_acc   = psel && penable && pwrite;
  assign hit_ctrl = addr == mqp_pkg::OFS_CTRL;
  assign hit_stat = addr == mqp_pkg::OFS_STAT;
  assign hit_any  = hit_ctrl || hit_stat || (|hit_ptr);
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !hit_any;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      queue_base_addr_r      <= mqp_pkg::BASE_RST;
      size_r                 <= mqp_pkg::SIZE_RST;
      bottom_read_option_r   <= 1'b0;
      queue_access_disable_r <= 1'b0;
    end else if (wr_acc && hit_ctrl) begin
      queue_base_addr_r      <= pwdata[mqp_pkg::BASE_LSB +: mqp_pkg::BASE_W];
      size_r                 <= pwdata[mqp_pkg::SIZE_LSB +: mqp_pkg::SIZE_W];
      bottom_read_option_r   <= pwdata[mqp_pkg::BRO_BIT];
      queue_access_disable_r <= pwdata[mqp_pkg::DIS_BIT];
    end
  end

  // ****************************************************
  // pointer registers
  // ****************************************************
  logic [17:0] off [mqp_pkg::NPTR];
  logic [6:0]  ptr_inc;
  logic [6:0]  ptr_wr;

  assign ptr_inc[mqp_pkg::P_IFT] = 1'b0;
  assign ptr_inc[mqp_pkg::P_IFB] = dev_inc.in_free_take;
  assign ptr_inc[mqp_pkg::P_IPT] = dev_inc.in_post_put;
  assign ptr_inc[mqp_pkg::P_IPB] = 1'b0;
  assign ptr_inc[mqp_pkg::P_OFT] = dev_inc.out_free_take;
  assign ptr_inc[mqp_pkg::P_OFB] = 1'b0;
  assign ptr_inc[mqp_pkg::P_OPT] = 1'b0;

  genvar gi;
  for (gi = 0; gi < mqp_pkg::NPTR; gi++) begin : g_ptr
    assign hit_ptr[gi] = addr == mqp_pkg::PTR_OFS[gi];
    assign ptr_wr[gi]  = wr_acc && hit_ptr[gi] && !queue_access_disable_r;
    mqp_ptr_reg #(
      .DEV_OWNED (mqp_pkg::DEV_OWN[gi])
    ) u_ptr (
      .pclk      (pclk),
      .presetn   (presetn),
      .wr_en     (ptr_wr[gi]),
      .wr_off    (pwdata[mqp_pkg::OFF_LSB +: mqp_pkg::OFF_W]),
      .inc       (ptr_inc[gi]),
      .size_code (size_r),
      .off_r     (off[gi])
    );
  end

  // ****************************************************
  // device view and flags
  // ****************************************************
  logic [2:0] q_eq;
  logic [2:0] q_full;
  logic [2:0] empty_r;
  logic [2:0] full_r;

  assign queue_addr.in_free_bottom  = mqp_pkg::mqp_word(queue_base_addr_r, off[mqp_pkg::P_IFB]);
  assign queue_addr.in_post_top     = mqp_pkg::mqp_word(queue_base_addr_r, off[mqp_pkg::P_IPT]);
  assign queue_addr.in_post_bottom  = mqp_pkg::mqp_word(queue_base_addr_r, off[mqp_pkg::P_IPB]);
  assign queue_addr.out_free_top    = mqp_pkg::mqp_word(queue_base_addr_r, off[mqp_pkg::P_OFT]);
  assign queue_addr.out_free_bottom = mqp_pkg::mqp_word(queue_base_addr_r, off[mqp_pkg::P_OFB]);
  assign queue_addr.out_post_top    = mqp_pkg::mqp_word(queue_base_addr_r, off[mqp_pkg::P_OPT]);

  for (gi = 0; gi < 3; gi++) begin : g_q
    assign q_eq[gi]   = off[2*gi] == off[2*gi+1];
    assign q_full[gi] = mqp_pkg::mqp_next_off(off[2*gi], size_r) == off[2*gi+1];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      empty_r <= 3'h7;
      full_r  <= 3'h0;
    end else begin
      empty_r <= q_eq;
      full_r  <= q_full;
    end
  end

  assign queue_flags.empty = empty_r;
  assign queue_flags.full  = full_r;

  // ****************************************************
  // read path
  // ****************************************************
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  logic [31:0] ptr_word;
  logic [31:0] rd_word;
  logic [2:0]  sel_idx;
  logic        bot_ones;
  logic [31:0] prdata_r;

  always_comb begin
    sel_idx = 3'h0;
    for (int i = 0; i < mqp_pkg::NPTR; i++) begin
      if (hit_ptr[i]) begin
        sel_idx = 3'(i);
      end
    end
  end

  assign ctrl_word = {queue_base_addr_r, 15'h0000, queue_access_disable_r,
                      bottom_read_option_r, size_r};
  assign stat_word = {25'h000_0000, full_r, 1'b0, empty_r};
  assign bot_ones  = bottom_read_option_r && mqp_pkg::BOT_SET[sel_idx]
                  && q_eq[sel_idx[2:1]];
  assign ptr_word  = (queue_access_disable_r || bot_ones) ? mqp_pkg::ALL_ONES
                   : mqp_pkg::mqp_word(queue_base_addr_r, off[sel_idx]);
  assign rd_word   = ({32{hit_ctrl}} & ctrl_word) | ({32{hit_stat}} & stat_word)
                   | ({32{|hit_ptr}} & ptr_word);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_r <= rd_word;
    end
  end

  assign prdata = prdata_r;

  // ****************************************************
  // checks
  // ****************************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic ifb_wr;
  logic ipt_wr;
  logic oft_wr;
  assign ifb_wr = ptr_wr[mqp_pkg::P_IFB];
  assign ipt_wr = ptr_wr[mqp_pkg::P_IPT];
  assign oft_wr = ptr_wr[mqp_pkg::P_OFT];

  property p_ifb_step;
    logic [17:0] o;
    (dev_inc.in_free_take && !ifb_wr, o = off[mqp_pkg::P_IFB]) |=>
      off[mqp_pkg::P_IFB] == mqp_pkg::mqp_next_off(o, $past(size_r));
  endproperty
  a_ifb_step: assert property (p_ifb_step) else $error("in free bottom step wrong");

  property p_ipt_step;
    logic [17:0] o;
    (dev_inc.in_post_put && !ipt_wr, o = off[mqp_pkg::P_IPT]) |=>
      off[mqp_pkg::P_IPT] == mqp_pkg::mqp_next_off(o, $past(size_r));
  endproperty
  a_ipt_step: assert property (p_ipt_step) else $error("in post top step wrong");

  property p_oft_step;
    (dev_inc.out_free_take && !oft_wr && size_r == mqp_pkg::SZ_256
      && off[mqp_pkg::P_OFT][7:0] != 8'hff) |=>
      off[mqp_pkg::P_OFT] == $past(off[mqp_pkg::P_OFT]) + mqp_pkg::OFF_ONE;
  endproperty
  a_oft_step: assert property (p_oft_step) else $error("out free top step wrong");

  property p_ipb_host;
    $changed(off[mqp_pkg::P_IPB]) |-> $past(ptr_wr[mqp_pkg::P_IPB]);
  endproperty
  a_ipb_host: assert property (p_ipb_host) else $error("in post bottom moved alone");

  property p_ofb_host;
    $changed(off[mqp_pkg::P_OFB]) |-> $past(ptr_wr[mqp_pkg::P_OFB]);
  endproperty
  a_ofb_host: assert property (p_ofb_host) else $error("out free bottom moved alone");

  property p_base_rd;
    (setup && !pwrite && (|hit_ptr) && !queue_access_disable_r && !bot_ones) |=>
      prdata[31:20] == $past(queue_base_addr_r) && prdata[1:0] == 2'b00;
  endproperty
  a_base_rd: assert property (p_base_rd) else $error("pointer read base or low bits wrong");

  property p_wrap;
    (dev_inc.in_post_put && !ipt_wr && size_r == mqp_pkg::SZ_1K
      && off[mqp_pkg::P_IPT][9:0] == 10'h3ff) ##1 1'b1 |->
      off[mqp_pkg::P_IPT][9:0] == 10'h000
      && off[mqp_pkg::P_IPT][17:10] == $past(off[mqp_pkg::P_IPT][17:10]);
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap at 1K entries");

  property p_dis_rd;
    (setup && !pwrite && (|hit_ptr) && queue_access_disable_r) |=>
      prdata == mqp_pkg::ALL_ONES;
  endproperty
  a_dis_rd: assert property (p_dis_rd) else $error("disabled read not all ones");

  property p_dis_wr;
    (wr_acc && hit_ptr[mqp_pkg::P_IPB] && queue_access_disable_r) |=>
      $stable(off[mqp_pkg::P_IPB]);
  endproperty
  a_dis_wr: assert property (p_dis_wr) else $error("disabled write took effect");

  property p_bot_opt;
    (setup && !pwrite && hit_ptr[mqp_pkg::P_IPB] && bottom_read_option_r
      && off[mqp_pkg::P_IPT] == off[mqp_pkg::P_IPB]) |=> prdata == mqp_pkg::ALL_ONES;
  endproperty
  a_bot_opt: assert property (p_bot_opt) else $error("bottom read option ignored");

  property p_empty;
    ##1 queue_flags.empty[1] == $past(off[mqp_pkg::P_IPT] == off[mqp_pkg::P_IPB]);
  endproperty
  a_empty: assert property (p_empty) else $error("in post empty flag stale");

  property p_size;
    (wr_acc && hit_ctrl) |=> size_r == $past(pwdata[mqp_pkg::SIZE_LSB +: mqp_pkg::SIZE_W]);
  endproperty
  a_size: assert property (p_size) else $error("size code not stored");

  property p_full;
    ##1 queue_flags.full[1]
      == $past(mqp_pkg::mqp_next_off(off[mqp_pkg::P_IPT], size_r) == off[mqp_pkg::P_IPB]);
  endproperty
  a_full: assert property (p_full) else $error("in post full flag stale");

  property p_of_empty;
    ##1 queue_flags.empty[2] == $past(off[mqp_pkg::P_OFT] == off[mqp_pkg::P_OFB]);
  endproperty
  a_of_empty: assert property (p_of_empty) else $error("out free empty stale");

  property p_base_keep;
    (wr_acc && (|hit_ptr)) |=> $stable(queue_base_addr_r);
  endproperty
  a_base_keep: assert property (p_base_keep) else $error("base changed");

  property p_bot_val;
    (setup && !pwrite && hit_ptr[mqp_pkg::P_IPB] && bottom_read_option_r
      && !queue_access_disable_r && off[mqp_pkg::P_IPT] != off[mqp_pkg::P_IPB]) |=>
      prdata == mqp_pkg::mqp_word($past(queue_base_addr_r), $past(off[mqp_pkg::P_IPB]));
  endproperty
  a_bot_val: assert property (p_bot_val) else $error("bottom option hid value");

  property p_ofb_dis;
    (wr_acc && hit_ptr[mqp_pkg::P_OFB] && queue_access_disable_r) |=>
      $stable(off[mqp_pkg::P_OFB]);
  endproperty
  a_ofb_dis: assert property (p_ofb_dis) else $error("disabled write landed");

  property p_wrap_64k;
    (dev_inc.out_free_take && !oft_wr && size_r == mqp_pkg::SZ_64K
      && off[mqp_pkg::P_OFT][15:0] == 16'hffff) |=>
      off[mqp_pkg::P_OFT][15:0] == 16'h0000
      && off[mqp_pkg::P_OFT][17:16] == $past(off[mqp_pkg::P_OFT][17:16]);
  endproperty
  a_wrap_64k: assert property (p_wrap_64k) else $error("no wrap at 64K entries");

endmodule

// File: core/mqp_pkg.sv
/*
  constants, field layouts, carriers and helpers for the message queue
  pointer registers.
  assumes a 32-bit apb register port and a 12-bit byte address window.
*/
package mqp_pkg;

  // ****************************************************
  // register offsets (byte addresses)
  // ****************************************************
  localparam int unsigned AW       = 12;
  localparam logic [11:0] OFS_CTRL = 12'h200;
  localparam logic [11:0] OFS_IFT  = 12'h204;
  localparam logic [11:0] OFS_IFB  = 12'h208;
  localparam logic [11:0] OFS_IPT  = 12'h20c;
  localparam logic [11:0] OFS_IPB  = 12'h210;
  localparam logic [11:0] OFS_OFT  = 12'h214;
  localparam logic [11:0] OFS_OFB  = 12'h218;
  localparam logic [11:0] OFS_OPT  = 12'h21c;
  localparam logic [11:0] OFS_STAT = 12'h224;

  // ****************************************************
  // pointer indices
  // ****************************************************
  localparam int unsigned NPTR    = 7;
  localparam int unsigned P_IFT   = 0;
  localparam int unsigned P_IFB   = 1;
  localparam int unsigned P_IPT   = 2;
  localparam int unsigned P_IPB   = 3;
  localparam int unsigned P_OFT   = 4;
  localparam int unsigned P_OFB   = 5;
  localparam int unsigned P_OPT   = 6;
  localparam logic [6:0]  DEV_OWN = 7'h16;
  localparam logic [6:0]  BOT_SET = 7'h2a;
  localparam logic [11:0] PTR_OFS [NPTR] = '{OFS_IFT, OFS_IFB, OFS_IPT, OFS_IPB,
                                             OFS_OFT, OFS_OFB, OFS_OPT};

  // ****************************************************
  // field layout and reset values
  // ****************************************************
  localparam int unsigned BASE_LSB = 20;
  localparam int unsigned BASE_W   = 12;
  localparam int unsigned OFF_LSB  = 2;
  localparam int unsigned OFF_W    = 18;
  localparam int unsigned SIZE_LSB = 0;
  localparam int unsigned SIZE_W   = 3;
  localparam int unsigned BRO_BIT  = 3;
  localparam int unsigned DIS_BIT  = 4;
  localparam int unsigned FULL_LSB = 4;
  localparam logic [31:0] ALL_ONES = 32'hffff_ffff;
  localparam logic [17:0] OFF_RST  = 18'h0_0000;
  localparam logic [17:0] OFF_ONE  = 18'h0_0001;
  localparam logic [11:0] BASE_RST = 12'h000;
  localparam logic [2:0]  SIZE_RST = 3'h0;

  // ****************************************************
  // queue size codes
  // ****************************************************
  localparam logic [2:0] SZ_256 = 3'h0;
  localparam logic [2:0] SZ_1K  = 3'h1;
  localparam logic [2:0] SZ_4K  = 3'h2;
  localparam logic [2:0] SZ_16K = 3'h3;
  localparam logic [2:0] SZ_64K = 3'h4;

  // ****************************************************
  // carriers
  // ****************************************************
  typedef struct packed {
    logic in_free_take;
    logic in_post_put;
    logic out_free_take;
  } mqp_inc_type;

  typedef struct packed {
    logic [2:0] empty;
    logic [2:0] full;
  } mqp_flags_type;

  typedef struct packed {
    logic [31:0] in_free_bottom;
    logic [31:0] in_post_top;
    logic [31:0] in_post_bottom;
    logic [31:0] out_free_top;
    logic [31:0] out_free_bottom;
    logic [31:0] out_post_top;
  } mqp_addr_type;

  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic [17:0] mqp_size_mask(input logic [2:0] code);
    case (code)
      SZ_256:  return 18'h0_00ff;
      SZ_1K:   return 18'h0_03ff;
      SZ_4K:   return 18'h0_0fff;
      SZ_16K:  return 18'h0_3fff;
      SZ_64K:  return 18'h0_ffff;
      default: return 18'h0_00ff;
    endcase
  endfunction

  function automatic logic [17:0] mqp_next_off(input logic [17:0] off,
                                               input logic [2:0]  code);
    logic [17:0] m;
    m = mqp_size_mask(code);
    return (off & ~m) | ((off + OFF_ONE) & m);
  endfunction

  function automatic logic [31:0] mqp_word(input logic [11:0] base,
                                           input logic [17:0] off);
    return {base, off, 2'b00};
  endfunction

endpackage

// File: core/mqp_ptr_reg.sv
/*
  one queue pointer offset register: software load, device advance.
  assumes write and advance strobes come from logic on pclk.
*/
`timescale 1ns/100ps
module mqp_ptr_reg #(
  parameter bit DEV_OWNED = 1'b0
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // software load
  input  wire logic        wr_en,
  input  wire logic [17:0] wr_off,
  // device advance
  input  wire logic        inc,
  input  wire logic [2:0]  size_code,
  // offset
  output logic      [17:0] off_r
);

  // ****************************************************
  // next offset
  // ****************************************************
  logic [17:0] off_nxt;
  logic        adv;

  assign adv     = DEV_OWNED && inc;
  assign off_nxt = wr_en ? wr_off
                 : adv   ? mqp_pkg::mqp_next_off(off_r, size_code)
                 : off_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      off_r <= mqp_pkg::OFF_RST;
    end else begin
      off_r <= off_nxt;
    end
  end

endmodule

// File: testbench/mqp_dev_model.sv
/*
  device-side queue engine model: turns bench requests into advance pulses.
  assumes requests are levels from the bench on pclk.
*/
`timescale 1ns/100ps
module mqp_dev_model (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // bench request
  input  wire mqp_pkg::mqp_inc_type req,
  // advance pulses
  output mqp_pkg::mqp_inc_type      dev_inc
);
  // ****************************************************
  // one pulse per request cycle
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_inc <= '0;
    end else begin
      dev_inc <= req;
    end
  end
endmodule

// File: testbench/mqp_regs_tb.sv
/*
  self-checking bench for the queue pointer registers over apb.
  assumes mqp_pkg and mqp_regs are compiled first.
*/
`timescale 1ns/100ps
module mqp_regs_tb;
  logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, q;
  logic                   e;
  mqp_pkg::mqp_inc_type   req, dev_inc;
  mqp_pkg::mqp_addr_type  queue_addr;
  mqp_pkg::mqp_flags_type queue_flags;
  int                     bad_count, n_checks;
  logic [17:0]            m;
  logic [11:0]            dev_ofs [3];

  // ****************************************************
  // instances and clock
  // ****************************************************
  mqp_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dev_inc(dev_inc), .queue_addr(queue_addr),
    .queue_flags(queue_flags));
  mqp_dev_model i_dev (.pclk(pclk), .presetn(presetn), .req(req), .dev_inc(dev_inc));

  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end

  // ****************************************************
  // tasks
  // ****************************************************
  task automatic print_verdict;
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      $display("BAD %0t no ready", $time);
      print_verdict();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask

  task automatic pulse(input logic [2:0] bits, input int n);
    repeat (n) begin
      @(posedge pclk);
      req <= bits;
      @(posedge pclk);
      req <= '0;
    end
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    bad_count = 0;
    n_checks  = 0;
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0000_0000;
    req       = '0;
    dev_ofs   = '{mqp_pkg::OFS_IFB, mqp_pkg::OFS_IPT, mqp_pkg::OFS_OFT};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // reset values
    for (int i = 0; i < 7; i++) rd(mqp_pkg::PTR_OFS[i], 32'h0000_0000);
    chk({26'h0, queue_flags}, 32'h0000_0038);
    // base mirror, ignored base bits and low bits
    wr(mqp_pkg::OFS_CTRL, 32'habc0_0000);
    rd(mqp_pkg::OFS_IPB, 32'habc0_0000);
    wr(mqp_pkg::OFS_IPB, 32'h1234_5677);
    rd(mqp_pkg::OFS_IPB, 32'habc4_5674);
    // every size code: wrap from last entry, then two steps of one word each
    for (int c = 0; c < 5; c++) begin
      wr(mqp_pkg::OFS_CTRL, 32'habc0_0000 | c);
      m = 18'((256 << (2 * c)) - 1);
      for (int i = 0; i < 3; i++) wr(dev_ofs[i], {12'habc, m, 2'b00});
      pulse(3'b111, 1);
      for (int i = 0; i < 3; i++) rd(dev_ofs[i], 32'habc0_0000);
      pulse(3'b111, 2);
      for (int i = 0; i < 3; i++) rd(dev_ofs[i], 32'habc0_0008);
    end
    // bottom read option and flags
    wr(mqp_pkg::OFS_CTRL, 32'habc0_000c);
    wr(mqp_pkg::OFS_IPB, 32'habc0_0008);
    rd(mqp_pkg::OFS_IPB, 32'hffff_ffff);
    chk({26'h0, queue_flags}, 32'h0000_0010);
    pulse(3'b010, 1);
    rd(mqp_pkg::OFS_IPB, 32'habc0_0008);
    chk(queue_addr.in_post_top, 32'habc0_000c);
    wr(mqp_pkg::OFS_IPB, 32'habc0_0010);
    rd(mqp_pkg::OFS_IPB, 32'habc0_0010);
    chk({26'h0, queue_flags}, 32'h0000_0002);
    chk(queue_addr.in_free_bottom, 32'habc0_0008);
    chk(queue_addr.in_post_bottom, 32'habc0_0010);
    chk(queue_addr.out_free_top, 32'habc0_0008);
    chk(queue_addr.out_free_bottom, 32'habc0_0000);
    chk(queue_addr.out_post_top, 32'habc0_0000);
    // disabled pointer access
    wr(mqp_pkg::OFS_CTRL, 32'habc0_0014);
    wr(mqp_pkg::OFS_OFB, 32'habc0_0040);
    rd(mqp_pkg::OFS_OFB, 32'hffff_ffff);
    wr(mqp_pkg::OFS_IPB, 32'habc0_0040);
    wr(mqp_pkg::OFS_CTRL, 32'habc0_0004);
    rd(mqp_pkg::OFS_OFB, 32'habc0_0000);
    chk({31'h0, e}, 32'h0000_0000);
    rd(mqp_pkg::OFS_IPB, 32'habc0_0010);
    // unmapped address
    rd(12'h220, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    print_verdict();
  end
endmodule
